// ==== logic/sesw_core.sv ====
// command interpreter for driver enable/disable, preset, reset-errors and the input image
// assumes motion, encoder and fault signals come from logic on sys_clk; only the e-stop pin is asynchronous
`timescale 1ns/100ps
module sesw_core
  import sesw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [10:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        cfg_mode,
  input  wire logic        config_valid,
  input  wire logic        internal_fault,
  input  wire logic        abs_enc_err,
  input  wire logic        estop_pin,
  input  wire logic        driver_fault,
  input  wire logic        input_fault_evt,
  input  wire logic        invalid_cmd_evt,
  input  wire logic        move_done_evt,
  input  wire logic        homed,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic        moving,
  input  wire logic        hold_state,
  input  wire logic        follower_active,
  input  wire logic        rotating_ccw,
  input  wire logic        rotating_cw,
  input  wire logic        pos_decreasing,
  input  wire logic [31:0] profile_pos,
  input  wire logic [31:0] encoder_pos,
  input  wire logic [31:0] trapped_pos,
  input  wire logic [15:0] current_mag,
  input  wire logic [15:0] velocity_mag,
  input  wire logic [31:0] max_pos_err,
  input  wire logic [13:0] status1_aux,
  output logic             driver_en,
  output logic             profile_load,
  output logic             encoder_load,
  output logic      [31:0] load_value,
  output logic             ctrl_stop,
  output logic             move_cmd,
  output logic      [15:0] move_cw0,
  output logic      [15:0] move_cw1
);

  sesw_state_t q;
  sesw_state_t d;

  logic        cw1_wr;
  logic        drive_cmd;
  logic        en_cmd;
  logic        en_plain;
  logic        en_pre;
  logic        en_bad;
  logic        dis_cmd;
  logic        preset_cmd;
  logic        rsterr_cmd;
  logic        move_req;
  logic        estop_act;
  logic        stopped;
  logic [32:0] pos_diff;
  logic        diff_big;
  logic        stall_now;
  logic [15:0] cur_s;
  logic [15:0] vel_s;
  logic [15:0] stat0;
  logic [15:0] stat1;

  function automatic logic [32:0] sesw_absdiff(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] t;
    t = {a[31], a} - {b[31], b};
    return t[32] ? 33'(~t + 33'h000000001) : t;
  endfunction

  // a command executes when word 1 is written; word 0 must already be in place
  assign cw1_wr     = reg_wr && (reg_addr == SESW_OFS_CW1);
  assign drive_cmd  = cw1_wr && (q.cw0 == SESW_CW0_DRIVE);
  assign en_cmd     = drive_cmd && reg_wdata[SESW_CW1_EN_BIT];
  assign en_plain   = en_cmd && (reg_wdata == SESW_CW1_EN);
  assign en_pre     = en_cmd && (reg_wdata == SESW_CW1_EN_PRE);
  assign en_bad     = en_cmd && !en_plain && !en_pre;
  assign dis_cmd    = drive_cmd && !reg_wdata[SESW_CW1_EN_BIT];
  assign preset_cmd = cw1_wr && (q.cw0 == SESW_CW0_PRESET);
  assign rsterr_cmd = cw1_wr && (q.cw0 == SESW_CW0_RSTERR);
  assign move_req   = cw1_wr && !drive_cmd && !preset_cmd && !rsterr_cmd;

  // only the second synchroniser stage is read
  assign estop_act  = q.es_sync[1];

  assign pos_diff   = sesw_absdiff(profile_pos, encoder_pos);
  assign diff_big   = pos_diff > SESW_EN_WINDOW;
  assign stall_now  = pos_diff > {1'b0, max_pos_err};

  assign stopped    = follower_active ? 1'b0 : !moving;

  // magnitudes come in unsigned; the sign follows the position trend
  assign cur_s = pos_decreasing ? 16'(~current_mag + 16'h0001) : current_mag;
  assign vel_s = pos_decreasing ? 16'(~velocity_mag + 16'h0001) : velocity_mag;

  assign stat0 = {cfg_mode,
                  !internal_fault,
                  !config_valid,
                  q.cmd_err,
                  q.in_err,
                  q.pos_bad,
                  2'b00,
                  q.move_done,
                  moving && decelerating,
                  moving && accelerating,
                  homed,
                  stopped,
                  hold_state,
                  rotating_ccw,
                  rotating_cw};
  assign stat1 = {q.drv_en, q.stall, status1_aux};

  always_comb begin
    d         = q;
    d.prof_ld = 1'b0;
    d.enc_ld  = 1'b0;
    d.stop    = 1'b0;
    d.mv      = 1'b0;
    d.es_sync = {q.es_sync[0], estop_pin};
    d.cfg_prev = cfg_mode;
    d.init    = 1'b1;

    if (reg_wr) begin
      unique case (reg_addr)
        SESW_OFS_CW0: begin
          d.cw0 = reg_wdata;
        end
        SESW_OFS_CW1: begin
          d.cw1 = reg_wdata;
        end
        SESW_OFS_CW2: begin
          d.cw2 = reg_wdata;
        end
        SESW_OFS_CW3: begin
          d.cw3 = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    unique case (q.en_st)
      SESW_EN_IDLE: begin
      end
      SESW_EN_PRESET: begin
        d.prof_ld = 1'b1;
        d.ld_val  = encoder_pos;
        d.en_st   = SESW_EN_GO;
      end
      SESW_EN_GO: begin
        d.drv_en = 1'b1;
        d.en_st  = SESW_EN_IDLE;
      end
      default: begin
        d.en_st = SESW_EN_IDLE;
      end
    endcase

    // clears first, so any set below wins in the same cycle
    if (rsterr_cmd) begin
      d.cmd_err   = 1'b0;
      d.in_err    = 1'b0;
      d.move_done = 1'b0;
      d.stall     = 1'b0;
    end
    if (preset_cmd) begin
      d.pos_bad   = 1'b0;
      d.move_done = 1'b0;
      d.prof_ld   = 1'b1;
      d.enc_ld    = 1'b1;
      d.ld_val    = {q.cw3, q.cw2};
    end

    if (en_plain) begin
      if (diff_big) begin
        d.cmd_err = 1'b1;
        d.pos_bad = 1'b1;
      end else begin
        d.drv_en = 1'b1;
      end
    end
    if (en_pre) begin
      d.en_st = SESW_EN_PRESET;
    end
    if (en_bad || invalid_cmd_evt) begin
      d.cmd_err = 1'b1;
    end
    if (dis_cmd) begin
      d.drv_en = 1'b0;
      d.en_st  = SESW_EN_IDLE;
      if (moving) begin
        d.stop    = 1'b1;
        d.cmd_err = 1'b1;
      end
    end
    if (move_req) begin
      d.move_done = 1'b0;
      if (q.drv_en) begin
        d.mv = 1'b1;
      end else begin
        d.cmd_err = 1'b1;
      end
    end
    if (cfg_mode && !q.cfg_prev && q.drv_en) begin
      d.cmd_err = 1'b1;
    end

    // e-stop is reported but does not remove current
    if (estop_act || input_fault_evt) begin
      d.in_err = 1'b1;
    end
    if (move_done_evt) begin
      d.move_done = 1'b1;
    end
    if (stall_now) begin
      d.stall = 1'b1;
    end
    if ((q.stall && !moving && stall_now) || (!q.init && abs_enc_err)) begin
      d.pos_bad = 1'b1;
    end
    if (driver_fault) begin
      d.drv_en = 1'b0;
      d.en_st  = SESW_EN_IDLE;
    end

    unique case (reg_addr)
      SESW_OFS_STAT0:         d.rdata = stat0;
      SESW_OFS_STAT1:         d.rdata = stat1;
      SESW_OFS_PROF:          d.rdata = profile_pos[15:0];
      SESW_OFS_PROF + 11'h1:  d.rdata = profile_pos[31:16];
      SESW_OFS_ENC:           d.rdata = encoder_pos[15:0];
      SESW_OFS_ENC + 11'h1:   d.rdata = encoder_pos[31:16];
      SESW_OFS_TRAP:          d.rdata = trapped_pos[15:0];
      SESW_OFS_TRAP + 11'h1:  d.rdata = trapped_pos[31:16];
      SESW_OFS_CURR:          d.rdata = cur_s;
      SESW_OFS_VEL:           d.rdata = vel_s;
      SESW_OFS_CW0:           d.rdata = q.cw0;
      SESW_OFS_CW1:           d.rdata = q.cw1;
      default:                d.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q.cw0       <= SESW_CW_RST;
      q.cw1       <= SESW_CW_RST;
      q.cw2       <= SESW_CW_RST;
      q.cw3       <= SESW_CW_RST;
      q.es_sync   <= 2'b00;
      q.cfg_prev  <= 1'b0;
      q.init      <= 1'b0;
      q.en_st     <= SESW_EN_IDLE;
      q.drv_en    <= 1'b0;
      q.cmd_err   <= 1'b0;
      q.in_err    <= 1'b0;
      q.pos_bad   <= 1'b0;
      q.move_done <= 1'b0;
      q.stall     <= 1'b0;
      q.prof_ld   <= 1'b0;
      q.enc_ld    <= 1'b0;
      q.stop      <= 1'b0;
      q.mv        <= 1'b0;
      q.ld_val    <= 32'h00000000;
      q.rdata     <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata    = q.rdata;
  assign driver_en    = q.drv_en;
  assign profile_load = q.prof_ld;
  assign encoder_load = q.enc_ld;
  assign load_value   = q.ld_val;
  assign ctrl_stop    = q.stop;
  assign move_cmd     = q.mv;
  assign move_cw0     = q.cw0;
  assign move_cw1     = q.cw1;

  default clocking sesw_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence sesw_seq_load;
    profile_load && (load_value == $past(encoder_pos));
  endsequence
  sequence sesw_seq_enable;
    driver_en;
  endsequence

  AST_EN_WINDOW: assert property (en_plain && !diff_big && !driver_fault && !dis_cmd |=> driver_en)
    else $error("enable inside window did not enable");
  AST_EN_REFUSE: assert property (en_plain && diff_big && !driver_en |=> !driver_en && stat0[SESW_S0_CMD])
    else $error("enable outside window was not refused");
  // the driver must still be off in the cycle in which the profile is loaded
  AST_PRESET_SEQ: assert property ((en_pre && !driver_en && !driver_fault) ##1 (!cw1_wr && !driver_fault) [*2]
                                   |-> !driver_en && profile_load)
    else $error("preset enable order broken");
  AST_PRESET_ORDER: assert property ((en_pre && !driver_fault) ##1 (!driver_fault && !dis_cmd && !cw1_wr) [*2]
                                     |-> sesw_seq_load ##1 sesw_seq_enable)
    else $error("profile not loaded before enable");
  AST_DISABLE_STOP: assert property (dis_cmd && moving |=> ctrl_stop && stat0[SESW_S0_CMD] && !driver_en)
    else $error("disable during move did not stop with error");
  AST_RSVD_ZERO: assert property (reg_addr == SESW_OFS_STAT0 |=> reg_rdata[9:8] == 2'b00)
    else $error("reserved status bits not zero");
  AST_RSTERR_CLR: assert property (rsterr_cmd && !invalid_cmd_evt && !move_done_evt && !estop_act
                                   && !input_fault_evt && !stall_now && !cfg_mode
                                   |=> !stat0[SESW_S0_CMD] && !stat0[SESW_S0_DONE] && !stat1[SESW_S1_STALL])
    else $error("reset errors did not clear flags");
  // a magnitude above 16'h8000 cannot be shown negative in 16 bits, so every magnitude with its top bit set is left out here
  AST_CUR_SIGN: assert property (reg_addr == SESW_OFS_CURR && pos_decreasing && current_mag != 16'h0000
                                 && !current_mag[15] |=> reg_rdata[15])
    else $error("current not negative while decreasing");
  AST_STALL_STICKY: assert property (stat1[SESW_S1_STALL] && !rsterr_cmd |=> stat1[SESW_S1_STALL])
    else $error("stall flag dropped without reset errors");
  AST_PRESET_CLR: assert property (preset_cmd && !q.stall && q.init |=> encoder_load && profile_load
                                   && !stat0[SESW_S0_POS] && load_value == $past({q.cw3, q.cw2}))
    else $error("preset did not load and clear");
  AST_ESTOP_KEEP: assert property (driver_en && !driver_fault && !dis_cmd |=> driver_en)
    else $error("driver dropped without disable or fault");

  // sticky command and input error flags only fall on a reset-errors command
  AST_CMDERR_STICKY: assert property (stat0[SESW_S0_CMD] && !rsterr_cmd |=> stat0[SESW_S0_CMD])
    else $error("command error dropped without reset errors");
  AST_INERR_STICKY: assert property (stat0[SESW_S0_INP] && !rsterr_cmd |=> stat0[SESW_S0_INP])
    else $error("input error dropped without reset errors");
  AST_INERR_SET: assert property (estop_act |=> stat0[SESW_S0_INP])
    else $error("emergency stop did not raise input error");

  // untrusted position survives reset-errors; only a preset clears it
  AST_POS_KEEP: assert property (stat0[SESW_S0_POS] && !preset_cmd |=> stat0[SESW_S0_POS])
    else $error("position untrusted flag dropped");

  AST_DONE_SET: assert property (move_done_evt |=> stat0[SESW_S0_DONE])
    else $error("move done not set after clean move end");

  AST_MOVE_REFUSE: assert property (move_req && !driver_en |=> !move_cmd && stat0[SESW_S0_CMD])
    else $error("move while disabled was not refused");
  AST_MOVE_FWD: assert property (move_req && driver_en |=> move_cmd)
    else $error("move while enabled was not forwarded");

  AST_MODE_BIT: assert property (reg_addr == SESW_OFS_STAT0 |=> reg_rdata[15] == $past(cfg_mode))
    else $error("mode bit does not follow configuration mode");

endmodule // sesw_core

// ==== logic/sesw_pkg.sv ====
// constants, state layout and enable sequencing for the servo enable/status word block
// assumes one 100 MHz clock domain; motion logic sits on the same clock
package sesw_pkg;

  localparam logic [10:0] SESW_OFS_STAT0 = 11'h000;
  localparam logic [10:0] SESW_OFS_STAT1 = 11'h001;
  localparam logic [10:0] SESW_OFS_PROF  = 11'h002;
  localparam logic [10:0] SESW_OFS_ENC   = 11'h004;
  localparam logic [10:0] SESW_OFS_TRAP  = 11'h006;
  localparam logic [10:0] SESW_OFS_CURR  = 11'h008;
  localparam logic [10:0] SESW_OFS_VEL   = 11'h009;
  localparam logic [10:0] SESW_OFS_CW0   = 11'h400;
  localparam logic [10:0] SESW_OFS_CW1   = 11'h401;
  localparam logic [10:0] SESW_OFS_CW2   = 11'h402;
  localparam logic [10:0] SESW_OFS_CW3   = 11'h403;

  localparam logic [15:0] SESW_CW0_DRIVE  = 16'h0000;
  localparam logic [15:0] SESW_CW0_PRESET = 16'h0200;
  localparam logic [15:0] SESW_CW0_RSTERR = 16'h0400;
  localparam logic [15:0] SESW_CW1_EN     = 16'h8000;
  localparam logic [15:0] SESW_CW1_EN_PRE = 16'hC000;
  localparam int          SESW_CW1_EN_BIT = 15;

  localparam logic [32:0] SESW_EN_WINDOW  = 33'h000001000;

  localparam int SESW_S0_MODE  = 15;
  localparam int SESW_S0_OK    = 14;
  localparam int SESW_S0_CFG   = 13;
  localparam int SESW_S0_CMD   = 12;
  localparam int SESW_S0_INP   = 11;
  localparam int SESW_S0_POS   = 10;
  localparam int SESW_S0_DONE  = 7;
  localparam int SESW_S1_DRV   = 15;
  localparam int SESW_S1_STALL = 14;

  localparam logic [15:0] SESW_CW_RST = 16'h0000;

  typedef enum logic [1:0] {
    SESW_EN_IDLE   = 2'b00,
    SESW_EN_PRESET = 2'b01,
    SESW_EN_GO     = 2'b11
  } sesw_en_t;

  typedef struct packed {
    logic [15:0] cw0;
    logic [15:0] cw1;
    logic [15:0] cw2;
    logic [15:0] cw3;
    logic [1:0]  es_sync;
    logic        cfg_prev;
    logic        init;
    sesw_en_t    en_st;
    logic        drv_en;
    logic        cmd_err;
    logic        in_err;
    logic        pos_bad;
    logic        move_done;
    logic        stall;
    logic        prof_ld;
    logic        enc_ld;
    logic        stop;
    logic        mv;
    logic [31:0] ld_val;
    logic [15:0] rdata;
  } sesw_state_t;

endpackage

// ==== dv/sesw_host.sv ====
// host-side model: writes command words and reads the input image
// assumes the core samples reg_* on the rising sys_clk edge
`timescale 1ns/100ps
module sesw_host
  import sesw_pkg::*;
(
  input  wire logic        sys_clk,
  output logic      [10:0] reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  = 11'h000;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one-cycle strobe; data is scrambled after release so stale words never look valid
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read data is registered, so it lands one edge after the address
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask
  // word 0 first: the word 1 write launches the command
  task automatic cmd(input logic [15:0] w0, input logic [15:0] w1);
    wr(SESW_OFS_CW0, w0);
    wr(SESW_OFS_CW1, w1);
  endtask
endmodule // sesw_host

// ==== dv/sesw_core_bench.sv ====
// self-checking bench for sesw_core: host model on the register port, bench plays the motion side
// assumes one 100 MHz clock; driver fault and the input-fault and invalid-command events stay idle
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sesw_core_bench;
  import sesw_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [10:0] reg_addr;
  logic        reg_wr, cfg_mode, config_valid, internal_fault, abs_enc_err, estop_pin, move_done_evt;
  logic [15:0] reg_wdata, reg_rdata, rd_val, current_mag, velocity_mag, move_cw0, move_cw1;
  logic        homed, accelerating, decelerating, moving, hold_state, follower_active;
  logic        rotating_ccw, rotating_cw, pos_decreasing;
  logic [31:0] profile_pos, encoder_pos, trapped_pos, max_pos_err, load_value, ld_seen;
  logic [13:0] status1_aux;
  logic        driver_en, profile_load, encoder_load, ctrl_stop, move_cmd;
  int          error_cnt = 0, samples_checked = 0, prof_cnt = 0, enc_cnt = 0, stop_cnt = 0, move_cnt = 0;
  // {follower, moving, accel, decel, homed, hold, ccw, cw} and the low status byte expected
  logic [7:0]  vec [4] = '{8'h62, 8'h55, 8'h38, 8'h80};
  logic [7:0]  vexp [4] = '{8'h22, 8'h45, 8'h18, 8'h00};
  logic [15:0] img [8];

  always #5 sys_clk = ~sys_clk;

  sesw_host i_sesw_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  sesw_core i_sesw_core (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_mode(cfg_mode), .config_valid(config_valid),
    .internal_fault(internal_fault), .abs_enc_err(abs_enc_err), .estop_pin(estop_pin), .driver_fault(1'b0),
    .input_fault_evt(1'b0), .invalid_cmd_evt(1'b0), .move_done_evt(move_done_evt), .homed(homed),
    .accelerating(accelerating), .decelerating(decelerating), .moving(moving), .hold_state(hold_state),
    .follower_active(follower_active), .rotating_ccw(rotating_ccw), .rotating_cw(rotating_cw),
    .pos_decreasing(pos_decreasing), .profile_pos(profile_pos), .encoder_pos(encoder_pos),
    .trapped_pos(trapped_pos), .current_mag(current_mag), .velocity_mag(velocity_mag),
    .max_pos_err(max_pos_err), .status1_aux(status1_aux), .driver_en(driver_en), .profile_load(profile_load),
    .encoder_load(encoder_load), .load_value(load_value), .ctrl_stop(ctrl_stop), .move_cmd(move_cmd),
    .move_cw0(move_cw0), .move_cw1(move_cw1));

  // pulses are counted here so the tests need not hit their exact cycle
  always @(posedge sys_clk) begin
    if (profile_load === 1'b1) begin
      prof_cnt++;
      ld_seen = load_value;
    end
    if (encoder_load === 1'b1) enc_cnt++;
    if (ctrl_stop === 1'b1) stop_cnt++;
    if (move_cmd === 1'b1) move_cnt++;
  end

  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic do_cmd(input logic [15:0] w0, input logic [15:0] w1);
    i_sesw_host.cmd(w0, w1);
    settle();
  endtask
  task automatic chk(input logic [10:0] a, input logic [15:0] m, input logic [15:0] e);
    i_sesw_host.rd(a, rd_val);
    `CHK(rd_val & m, e)
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200us;
    error_cnt++;
    complete_run();
  end

  initial begin
    {cfg_mode, internal_fault, estop_pin, move_done_evt, pos_decreasing} = 5'h00;
    {follower_active, moving, accelerating, decelerating, homed, hold_state, rotating_ccw, rotating_cw} = 8'h00;
    config_valid = 1'b1;
    abs_enc_err = 1'b1;
    profile_pos = 32'h0000_1000;
    encoder_pos = 32'h0000_0000;
    trapped_pos = 32'h1234_5678;
    max_pos_err = 32'h0010_0000;
    current_mag = 16'h0123;
    velocity_mag = 16'h0045;
    status1_aux = 14'h02A5;
    img = '{16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h5678, 16'h1234, 16'h0123, 16'h0045};
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    settle();
    abs_enc_err <= 1'b0;
    chk(SESW_OFS_STAT0, 16'hFFFF, 16'h4408);
    chk(SESW_OFS_STAT1, 16'hFFFF, 16'h02A5);
    for (int i = 0; i < 8; i++) chk(11'(i + 2), 16'hFFFF, img[i]);
    pos_decreasing <= 1'b1;
    chk(SESW_OFS_CURR, 16'hFFFF, 16'hFEDD);
    chk(SESW_OFS_VEL, 16'hFFFF, 16'hFFBB);
    pos_decreasing <= 1'b0;
    // preset takes its value from words 2 and 3
    i_sesw_host.wr(SESW_OFS_CW2, 16'hBEEF);
    i_sesw_host.wr(SESW_OFS_CW3, 16'h0012);
    do_cmd(SESW_CW0_PRESET, 16'h0000);
    `CHK(prof_cnt + enc_cnt, 2)
    `CHK(ld_seen, 32'h0012_BEEF)
    chk(SESW_OFS_STAT0, 16'h0480, 16'h0000);
    // difference of exactly 4096 still enables
    do_cmd(SESW_CW0_DRIVE, SESW_CW1_EN);
    `CHK(driver_en, 1'b1)
    chk(SESW_OFS_STAT1, 16'h8000, 16'h8000);
    chk(SESW_OFS_STAT0, 16'h1400, 16'h0000);
    moving <= 1'b1;
    do_cmd(SESW_CW0_DRIVE, 16'h0000);
    `CHK(driver_en, 1'b0)
    `CHK(stop_cnt, 1)
    chk(SESW_OFS_STAT0, 16'h1000, 16'h1000);
    moving <= 1'b0;
    do_cmd(SESW_CW0_RSTERR, 16'h0000);
    chk(SESW_OFS_STAT0, 16'h1000, 16'h0000);
    profile_pos <= 32'h0000_1001;
    do_cmd(SESW_CW0_DRIVE, SESW_CW1_EN);
    `CHK(driver_en, 1'b0)
    chk(SESW_OFS_STAT0, 16'h1400, 16'h1400);
    do_cmd(SESW_CW0_RSTERR, 16'h0000);
    chk(SESW_OFS_STAT0, 16'h1400, 16'h0400);
    // stale words 2 and 3 must not disturb the preset-on-enable
    i_sesw_host.wr(SESW_OFS_CW2, 16'hDEAD);
    i_sesw_host.wr(SESW_OFS_CW3, 16'hFFFF);
    profile_pos <= 32'h0000_0000;
    encoder_pos <= 32'h0002_0000;
    do_cmd(SESW_CW0_DRIVE, SESW_CW1_EN_PRE);
    `CHK(prof_cnt, 2)
    `CHK(enc_cnt, 1)
    `CHK(ld_seen, 32'h0002_0000)
    `CHK(driver_en, 1'b1)
    chk(SESW_OFS_STAT0, 16'h1000, 16'h0000);
    @(posedge sys_clk);
    estop_pin <= 1'b1;
    move_done_evt <= 1'b1;
    @(posedge sys_clk);
    move_done_evt <= 1'b0;
    settle();
    estop_pin <= 1'b0;
    `CHK(driver_en, 1'b1)
    chk(SESW_OFS_STAT0, 16'h0880, 16'h0880);
    cfg_mode <= 1'b1;
    settle();
    chk(SESW_OFS_STAT0, 16'h9000, 16'h9000);
    cfg_mode <= 1'b0;
    do_cmd(SESW_CW0_RSTERR, 16'h0000);
    chk(SESW_OFS_STAT0, 16'h1880, 16'h0000);
    // a move while enabled is forwarded with the stored words
    do_cmd(16'h0100, 16'h0080);
    `CHK(move_cnt, 1)
    `CHK({move_cw0, move_cw1}, 32'h0100_0080)
    chk(SESW_OFS_STAT0, 16'h1000, 16'h0000);
    // disable at rest is not an error; a move while disabled is
    do_cmd(SESW_CW0_DRIVE, 16'h0000);
    `CHK(stop_cnt, 1)
    chk(SESW_OFS_STAT0, 16'h1000, 16'h0000);
    do_cmd(16'h0100, 16'h0000);
    `CHK(move_cnt, 1)
    chk(SESW_OFS_STAT0, 16'h1000, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      {follower_active, moving, accelerating, decelerating, homed, hold_state, rotating_ccw, rotating_cw} <= vec[i];
      chk(SESW_OFS_STAT0, 16'h007F, {8'h00, vexp[i]});
    end
    {follower_active, moving, accelerating, decelerating, homed, hold_state, rotating_ccw, rotating_cw} <= 8'h00;
    internal_fault <= 1'b1;
    config_valid <= 1'b0;
    chk(SESW_OFS_STAT0, 16'hE000, 16'h2000);
    max_pos_err <= 32'h0000_0064;
    encoder_pos <= 32'h0000_00C8;
    settle();
    chk(SESW_OFS_STAT1, 16'h4000, 16'h4000);
    encoder_pos <= 32'h0000_0000;
    do_cmd(SESW_CW0_RSTERR, 16'h0000);
    chk(SESW_OFS_STAT1, 16'h4000, 16'h0000);
    complete_run();
  end
endmodule // sesw_core_bench
